// File: core/lhp_serial_port.sv
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Receive on writes, transmit on reads.
// - One bit per clock; data steady high.
// - Data fall/rise with clock high: start/stop.
// - Drive low acknowledge after each written byte.
// - Read ends at stop or start, not nack; the code also ends it at a nack.
// - Pointer byte above 0Fh: ignore, still acknowledge.
// - Each byte advances pointer, parking at 10h.
// - Reads begin at the current pointer.
// - Read address: send data at once, advancing.
// - Address bits 7..3 fixed, 2..1 from straps.
// - Address bit 0: zero writes, one reads.
// - Chip enable high resets the three-wire side.
// - Sample on rising, drive after falling edge.
// - Eight-bit units, most significant bit first.
// - First byte: direction, 00, five-bit pointer.
// - Pointer advances every eighth data bit.
// - Three-wire read runs until chip enable high.
module lhp_serial_port (
    input wire logic ref_clk, // Core clock, 20 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic scl, // Two-wire clock pin.
    input wire logic sda_in, // Two-wire data pin, level seen.
    output logic sda_out, // Two-wire data pin, always low.
    output logic sda_oe, // High while pulling the data pin low.
    input wire logic addr_strap_low_bit, // Strap for address bit 1.
    input wire logic addr_strap_high_bit, // Strap for address bit 2.
    input wire logic spi_sclk, // Three-wire serial clock.
    input wire logic spi_ce_n, // Three-wire chip enable, active low.
    input wire logic spi_sdio_in, // Shared data pin, input side.
    output logic spi_sdio_out, // Shared data pin, output side.
    output logic spi_sdio_oe, // High while driving the shared pin.
    output lhp_pkg::lhp_regs_t reg_file, // Register contents.
    output logic wr_strobe, // One-cycle pulse per register write; a link write and a two-wire write in the same cycle share one pulse.
    output logic [3:0] wr_index, // Index of the register written.
    output logic [7:0] wr_data // Value written.
);

    // Whole core-clock state of the block.
    typedef struct packed {
        lhp_pkg::lhp_i2c_e st; // Two-wire slave state.
        logic [3:0] bits; // Bits handled in the current byte.
        logic [7:0] shreg; // Byte in or byte out.
        logic [1:0] stage; // Role of the next received byte.
        logic rw; // Transfer is a read.
        logic ign; // Pointer byte was out of range.
        logic [4:0] ptr; // Two-wire register pointer.
        logic sda_oe; // Pull on the data pin.
        logic [3:0] s1; // First synchroniser stage of the pins.
        logic [3:0] s2; // Second synchroniser stage.
        logic [1:0] prev; // Previous clock and data levels.
        logic t1; // First stage of the write toggle.
        logic t2; // Second stage of the write toggle.
        logic seen; // Last toggle value acted on.
        logic link_rst; // Reset handed to the link hand-over.
        logic wr_strobe; // Write pulse.
        logic [3:0] wr_index; // Write index.
        logic [7:0] wr_data; // Write value.
        lhp_pkg::lhp_regs_t regs; // Register space.
    } lhp_core_s;

    lhp_core_s q, next_q; // Current and next state.
    logic spi_tog; // Write toggle from the link domain.
    lhp_pkg::lhp_wr_s spi_wr; // Held write from the link domain.
    logic scl_s, sda_s, scl_p, sda_p; // Synchronised levels.
    logic rise, fall, start_c, stop_c; // Bus events.
    logic [6:0] own_addr; // Address with straps, without direction.
    logic [7:0] rd_byte; // Register at the two-wire pointer.

    // The three-wire side lives on its own clock.
    lhp_spi_link u_link (
        .spi_sclk(spi_sclk),
        .spi_ce_n(spi_ce_n),
        .sdio_in(spi_sdio_in),
        .sdio_out(spi_sdio_out),
        .sdio_oe(spi_sdio_oe),
        .link_rst(q.link_rst),
        .reg_file(q.regs),
        .wr_toggle(spi_tog),
        .wr_req(spi_wr)
    );

    // Edge and condition detection works on the second stage only.
    assign scl_s = q.s2[3];
    assign sda_s = q.s2[2];
    assign scl_p = q.prev[1];
    assign sda_p = q.prev[0];
    assign rise = scl_s && !scl_p;
    assign fall = !scl_s && scl_p;
    assign start_c = scl_s && scl_p && sda_p && !sda_s;
    assign stop_c = scl_s && scl_p && !sda_p && sda_s;
    assign own_addr = {lhp_pkg::I2C_ADDR_FIXED, q.s2[1], q.s2[0]};
    assign rd_byte = lhp_pkg::lhp_reg_pick(q.regs, q.ptr);

    // Next-state logic for the whole block.
    always_comb begin
        next_q = q;
        next_q.wr_strobe = 1'b0;
        next_q.link_rst = rst;
        next_q.s1 = {scl, sda_in, addr_strap_high_bit, addr_strap_low_bit};
        next_q.s2 = q.s1;
        next_q.prev = q.s2[3:2];
        next_q.t1 = spi_tog;
        next_q.t2 = q.t1;

        // A write from the link side; the held word is stable by now.
        if (q.t2 != q.seen) begin
            next_q.seen = q.t2;
            next_q.regs[spi_wr.idx] = spi_wr.data;
            next_q.wr_strobe = 1'b1;
            next_q.wr_index = spi_wr.idx;
            next_q.wr_data = spi_wr.data;
        end

        // Stop and start win over any state, so a read never waits
        // for a final not-acknowledge.
        if (stop_c) begin
            next_q.st = lhp_pkg::ST_IDLE;
            next_q.sda_oe = 1'b0;
        end else if (start_c) begin
            next_q.st = lhp_pkg::ST_RX;
            next_q.bits = 4'h0;
            next_q.stage = lhp_pkg::STAGE_ADDR;
            next_q.sda_oe = 1'b0;
        end else begin
            case (q.st)
                lhp_pkg::ST_IDLE: begin
                    // Nothing until a start.
                    next_q.sda_oe = 1'b0;
                end
                lhp_pkg::ST_RX: begin
                    // Take one bit per clock while it is high.
                    if (rise && q.bits < lhp_pkg::I2C_BYTE_DONE) begin
                        next_q.shreg = {q.shreg[6:0], sda_s};
                        next_q.bits = 4'(q.bits + 4'h1);
                    end else if (fall && q.bits == lhp_pkg::I2C_BYTE_DONE)
                    begin
                        next_q.st = lhp_pkg::ST_ACK;
                        next_q.sda_oe = 1'b1;
                        case (q.stage)
                            lhp_pkg::STAGE_ADDR: begin
                                // Another address: let go of the bus.
                                if (q.shreg[7:1] != own_addr) begin
                                    next_q.st = lhp_pkg::ST_IDLE;
                                    next_q.sda_oe = 1'b0;
                                end
                                next_q.rw = q.shreg[lhp_pkg::I2C_RW_BIT];
                                next_q.stage = lhp_pkg::STAGE_PTR;
                            end
                            lhp_pkg::STAGE_PTR: begin
                                // Out of range keeps the old pointer.
                                next_q.ign = (q.shreg >= 8'(lhp_pkg::PTR_END));
                                if (q.shreg < 8'(lhp_pkg::PTR_END)) begin
                                    next_q.ptr = q.shreg[4:0];
                                end
                                next_q.stage = lhp_pkg::STAGE_DATA;
                            end
                            default: begin
                                // Data byte, acknowledged even if ignored.
                                if (!q.ign && q.ptr < lhp_pkg::PTR_END) begin
                                    next_q.regs[q.ptr[3:0]] = q.shreg;
                                    next_q.wr_strobe = 1'b1;
                                    next_q.wr_index = q.ptr[3:0];
                                    next_q.wr_data = q.shreg;
                                end
                                if (!q.ign) begin
                                    next_q.ptr = lhp_pkg::lhp_ptr_next(q.ptr);
                                end
                            end
                        endcase
                    end
                end
                lhp_pkg::ST_ACK, lhp_pkg::ST_RACK: begin
                    // The master's answer to a read byte is kept in the
                    // low bit of the byte register, which is free now.
                    if (rise && q.st == lhp_pkg::ST_RACK) begin
                        next_q.shreg[0] = sda_s;
                    end
                    // End of the ninth clock: next byte in or out.
                    if (fall) begin
                        if (q.st == lhp_pkg::ST_ACK && !q.rw) begin
                            next_q.st = lhp_pkg::ST_RX;
                            next_q.sda_oe = 1'b0;
                            next_q.bits = 4'h0;
                        end else if (q.st == lhp_pkg::ST_RACK && q.shreg[0])
                        begin
                            // A not-acknowledge ends the output. Without
                            // it the next byte goes out, and a stop only
                            // gets through if that byte starts with a one.
                            next_q.st = lhp_pkg::ST_IDLE;
                            next_q.sda_oe = 1'b0;
                        end else begin
                            // Read data goes out at once from the pointer.
                            next_q.st = lhp_pkg::ST_TX;
                            next_q.shreg = rd_byte;
                            next_q.sda_oe = !rd_byte[7];
                            next_q.bits = 4'h0;
                            next_q.ptr = lhp_pkg::lhp_ptr_next(q.ptr);
                        end
                    end
                end
                lhp_pkg::ST_TX: begin
                    // Data changes only while the clock is low.
                    if (fall) begin
                        if (q.bits == lhp_pkg::I2C_TX_LAST) begin
                            next_q.st = lhp_pkg::ST_RACK;
                            next_q.sda_oe = 1'b0;
                        end else begin
                            next_q.shreg = {q.shreg[6:0], 1'b0};
                            next_q.sda_oe = !q.shreg[6];
                            next_q.bits = 4'(q.bits + 4'h1);
                        end
                    end
                end
                default: begin
                    // A corrupted state code falls back to idle.
                    next_q.st = lhp_pkg::ST_IDLE;
                    next_q.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // State register; the clock and data synchronisers are reset to the idle levels, the strap bits to zero.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            q <= '0;
            q.st <= lhp_pkg::ST_IDLE;
            q.ptr <= lhp_pkg::PTR_RESET;
            q.regs <= {lhp_pkg::REG_COUNT{lhp_pkg::REG_RESET}};
            q.link_rst <= 1'b1;
            // Pins idle high, so the edge history starts high as well
            // and the end of reset shows no false clock edge.
            q.s1[3:2] <= lhp_pkg::PIN_IDLE;
            q.s2[3:2] <= lhp_pkg::PIN_IDLE;
            q.prev <= lhp_pkg::PIN_IDLE;
        end else begin
            q <= next_q;
        end
    end

    // Open drain: the pin is only ever pulled low.
    assign sda_out = 1'b0;
    assign sda_oe = q.sda_oe;
    assign reg_file = q.regs;
    assign wr_strobe = q.wr_strobe;
    assign wr_index = q.wr_index;
    assign wr_data = q.wr_data;

    // Checks of the two-wire side and of the link write hand-over; each guards one rule.
    AST_START_RX: assert property (
        @(posedge ref_clk) disable iff (rst)
        start_c |=> (q.st == lhp_pkg::ST_RX) && (q.bits == 4'h0))
        else $error("start not followed by address reception");

    AST_STOP_IDLE: assert property (
        @(posedge ref_clk) disable iff (rst)
        stop_c |=> (q.st == lhp_pkg::ST_IDLE) && !q.sda_oe)
        else $error("stop did not release the bus");

    AST_ACK_DRIVE: assert property (
        @(posedge ref_clk) disable iff (rst)
        (q.st == lhp_pkg::ST_ACK) |-> q.sda_oe)
        else $error("acknowledge not driven low");

    AST_PTR_SAT: assert property (
        @(posedge ref_clk) disable iff (rst)
        q.ptr <= lhp_pkg::PTR_END)
        else $error("pointer passed its park value");

    AST_ADDR_MISMATCH: assert property (
        @(posedge ref_clk) disable iff (rst)
        (q.st == lhp_pkg::ST_RX && fall && !start_c && !stop_c
         && q.bits == lhp_pkg::I2C_BYTE_DONE
         && q.stage == lhp_pkg::STAGE_ADDR && q.shreg[7:1] != own_addr)
        |=> (q.st == lhp_pkg::ST_IDLE) && !q.sda_oe)
        else $error("foreign address was answered");

    AST_SPI_WR_APPLY: assert property (
        @(posedge ref_clk) disable iff (rst)
        (q.t2 != q.seen) |=> q.wr_strobe && (q.seen == $past(q.t2)))
        else $error("link write was not applied");

    AST_TX_LOAD: assert property (
        @(posedge ref_clk) disable iff (rst)
        (q.st == lhp_pkg::ST_RACK && fall && !q.shreg[0])
        |=> ((q.st == lhp_pkg::ST_TX) && (q.bits == 4'h0))
        ##1 (q.st == lhp_pkg::ST_TX))
        else $error("next read byte not loaded after the ninth clock");

    AST_NACK_RELEASE: assert property (
        @(posedge ref_clk) disable iff (rst)
        (q.st == lhp_pkg::ST_RACK && fall && q.shreg[0])
        |=> (q.st == lhp_pkg::ST_IDLE) && !q.sda_oe)
        else $error("read output went on after a not-acknowledge");

endmodule

`default_nettype wire

// File: core/lhp_pkg.sv
package lhp_pkg;

    // Register space seen by the bus master.
    localparam int REG_COUNT = 16;
    localparam logic [4:0] PTR_END = 5'h10; // Pointer parks here.
    localparam logic [4:0] PTR_RESET = 5'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_PAST_END = 8'h00; // Data read at the park.
    localparam logic [1:0] PIN_IDLE = 2'h3; // Clock and data idle high.

    // Two-wire address byte layout.
    localparam logic [4:0] I2C_ADDR_FIXED = 5'h0E; // Pattern 01110.
    localparam int I2C_RW_BIT = 0;
    localparam logic [3:0] I2C_BYTE_DONE = 4'h8; // Bits per byte.
    localparam logic [3:0] I2C_TX_LAST = 4'h7; // Last driven bit.

    // Two-wire byte roles inside one transfer.
    localparam logic [1:0] STAGE_ADDR = 2'h0;
    localparam logic [1:0] STAGE_PTR = 2'h1;
    localparam logic [1:0] STAGE_DATA = 2'h2;

    // Three-wire address byte layout.
    localparam int SPI_RW_BIT = 7;
    localparam int SPI_PAD_MSB = 6;
    localparam int SPI_PAD_LSB = 5;
    localparam logic [1:0] SPI_PAD_VAL = 2'h0;
    localparam int SPI_PTR_MSB = 4;
    localparam logic [2:0] SPI_BIT_LAST = 3'h7;

    // Storage of the whole register space, entry 0 in the low byte.
    typedef logic [REG_COUNT-1:0][7:0] lhp_regs_t;

    // One register write handed from the link domain.
    typedef struct packed {
        logic [3:0] idx; // Register index.
        logic [7:0] data; // Value to store.
    } lhp_wr_s;

    // Two-wire slave states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_RACK = 5'h10
    } lhp_i2c_e;

    // Pointer advance that stops at the park value.
    function automatic logic [4:0] lhp_ptr_next(input logic [4:0] p);
        logic [4:0] v;
        v = (p >= PTR_END) ? PTR_END : 5'(p + 5'h01);
        return v;
    endfunction

    // Register read; the park value and beyond read as a constant.
    function automatic logic [7:0] lhp_reg_pick(input lhp_regs_t r,
                                                input logic [4:0] p);
        logic [7:0] v;
        v = (p < PTR_END) ? r[p[3:0]] : READ_PAST_END;
        return v;
    endfunction

endpackage

// File: core/lhp_spi_link.sv
`timescale 1ns/1ns
`default_nettype none

// Three-wire slave; everything here runs on the serial clock.
module lhp_spi_link (
    input wire logic spi_sclk, // Serial clock from the master.
    input wire logic spi_ce_n, // Chip enable, active low.
    input wire logic sdio_in, // Shared data pin, input side.
    output logic sdio_out, // Shared data pin, output side.
    output logic sdio_oe, // High while this end drives the pin.
    input wire logic link_rst, // Reset for the hand-over stage.
    input wire lhp_pkg::lhp_regs_t reg_file, // Quasi-static registers.
    output logic wr_toggle, // Flips once per register write.
    output lhp_pkg::lhp_wr_s wr_req // Held until the next write.
);

    // Rising-edge state, cleared whenever chip enable is high.
    typedef struct packed {
        logic [2:0] bits; // Bits taken in the current byte.
        logic [6:0] shreg; // Bits taken so far, newest low.
        logic addr_done; // Address byte complete.
        logic rw; // Read requested.
        logic ok; // Address byte was valid.
        logic [4:0] ptr; // Register pointer.
    } lhp_spi_s;

    // Hand-over stage; must outlive chip enable, so a separate reset.
    typedef struct packed {
        logic tog;
        lhp_pkg::lhp_wr_s wr;
    } lhp_hand_s;

    // Falling-edge output state.
    typedef struct packed {
        logic [7:0] oshift; // Byte being shifted out.
        logic oe; // Pin drive.
    } lhp_out_s;

    lhp_spi_s q, next_q; // Input side state.
    lhp_hand_s h, next_h; // Hand-over state.
    lhp_out_s o, next_o; // Output side state.
    logic [7:0] byte_in; // Byte completed by this edge.

    assign byte_in = {q.shreg, sdio_in};

    // Input bits are taken on the rising edge, MSB first.
    always_comb begin
        next_q = q;
        next_h = h;
        next_q.shreg = byte_in[6:0];
        next_q.bits = 3'(q.bits + 3'h1);
        if (q.bits == lhp_pkg::SPI_BIT_LAST) begin
            if (!q.addr_done) begin
                // First byte: direction, padding and pointer.
                next_q.addr_done = 1'b1;
                next_q.rw = byte_in[lhp_pkg::SPI_RW_BIT];
                next_q.ok = (byte_in[lhp_pkg::SPI_PAD_MSB:
                                     lhp_pkg::SPI_PAD_LSB]
                             == lhp_pkg::SPI_PAD_VAL)
                            && (byte_in[lhp_pkg::SPI_PTR_MSB:0]
                                < lhp_pkg::PTR_END);
                next_q.ptr = byte_in[lhp_pkg::SPI_PTR_MSB:0];
            end else begin
                // A data byte: store it if writing, then advance.
                if (q.ok && !q.rw && q.ptr < lhp_pkg::PTR_END) begin
                    next_h.wr.idx = q.ptr[3:0];
                    next_h.wr.data = byte_in;
                    next_h.tog = ~h.tog;
                end
                next_q.ptr = lhp_pkg::lhp_ptr_next(q.ptr);
            end
        end
    end

    // Chip enable high holds the input side in reset.
    always_ff @(posedge spi_sclk or posedge spi_ce_n) begin
        if (spi_ce_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // The hand-over must survive chip enable going high right after
    // the last bit, so only the core reset clears it.
    always_ff @(posedge spi_sclk or posedge link_rst) begin
        if (link_rst) begin
            h <= '0;
        end else begin
            h <= next_h;
        end
    end

    // Output bits change after the falling edge; a new byte is loaded
    // when the input side sits on a byte boundary of a valid read.
    always_comb begin
        next_o = o;
        if (q.addr_done && q.rw && q.ok && q.bits == 3'h0) begin
            next_o.oshift = lhp_pkg::lhp_reg_pick(reg_file, q.ptr);
            next_o.oe = 1'b1;
        end else begin
            next_o.oshift = {o.oshift[6:0], 1'b0};
        end
    end

    // Chip enable high releases the pin at once.
    always_ff @(negedge spi_sclk or posedge spi_ce_n) begin
        if (spi_ce_n) begin
            o <= '0;
        end else begin
            o <= next_o;
        end
    end

    assign sdio_out = o.oshift[7];
    assign sdio_oe = o.oe;
    assign wr_toggle = h.tog;
    assign wr_req = h.wr;

    AST_SPI_OE_ADDR: assert property (
        @(posedge spi_sclk) disable iff (spi_ce_n)
        !q.addr_done |-> !o.oe)
        else $error("data pin driven during the address byte");

    AST_SPI_PTR_SAT: assert property (
        @(posedge spi_sclk) disable iff (spi_ce_n)
        (q.addr_done && q.ok) |-> q.ptr <= lhp_pkg::PTR_END)
        else $error("link pointer passed its park value");

endmodule

`default_nettype wire

// File: testbench/lhp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// Bus master for both ports; it also resolves the shared wire levels.
module lhp_host_model (
    input wire logic ref_clk, // Paces the two-wire bus.
    input wire logic sda_oe, // Device pulls data low.
    input wire logic sdio_out, // Device value on the shared pin.
    input wire logic sdio_oe, // Device drives the shared pin.
    output logic scl, // Two-wire clock.
    output logic sda, // Two-wire data level.
    output logic sclk, // Three-wire clock, still outside frames.
    output logic ce_n, // Chip enable, active low.
    output logic sdio // Shared pin level.
);
    logic sda_m = 1'b1; // Master data; one releases the line.
    logic m_oe = 1'b0; // Master drives the shared pin.
    logic m_val = 1'b0; // Master value on the shared pin.
    logic last = 1'b0; // Last pin level seen.

    // Pull-up on data; an undriven shared pin shows the inverse level.
    assign sda = (sda_oe || !sda_m) ? 1'b0 : 1'b1;
    assign sdio = sdio_oe ? sdio_out : (m_oe ? m_val : ~last);
    always @(posedge sclk) begin
        last <= sdio;
    end
    initial begin
        scl = 1'b1;
        sclk = 1'b0;
        ce_n = 1'b0;
        // A clean rising edge resets the link side at start-up.
        #5;
        ce_n = 1'b1;
    end
    task automatic clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Works from idle and as a repeated start.
    task automatic i2c_start();
        sda_m <= 1'b1;
        clk(3);
        scl <= 1'b1;
        clk(5);
        sda_m <= 1'b0;
        clk(5);
        scl <= 1'b0;
        clk(1);
    endtask
    task automatic i2c_stop();
        sda_m <= 1'b0;
        clk(3);
        scl <= 1'b1;
        clk(5);
        sda_m <= 1'b1;
        clk(5);
    endtask
    // Data changes only while the clock is low.
    task automatic i2c_bit(input logic b, output logic r);
        sda_m <= b;
        clk(4);
        scl <= 1'b1;
        clk(5);
        r = sda;
        scl <= 1'b0;
        clk(2);
    endtask
    task automatic i2c_byte(input logic [7:0] tx, input logic am,
                            output logic [7:0] rx, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(tx[i], rx[i]);
        end
        i2c_bit(am, ak);
    endtask
    task automatic spi_open();
        ce_n = 1'b0;
        #40;
    endtask
    // Chip enable always returns high after a frame.
    task automatic spi_close();
        m_oe = 1'b0;
        #20;
        ce_n = 1'b1;
        #100;
    endtask
    // Written bytes are spaced so the crossing keeps up.
    task automatic spi_byte(input logic [7:0] tx, input logic rd,
                            output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            m_oe = !rd;
            m_val = tx[i];
            #3;
            sclk = 1'b1;
            rx[i] = sdio;
            #3;
            sclk = 1'b0;
        end
        if (!rd) begin
            #250;
        end
    endtask
endmodule

`default_nettype wire

// File: testbench/tb_lhp_serial_port.sv
`timescale 1ns/1ns
`default_nettype none

// Runs both ports against the host model and judges each scenario.
module tb_lhp_serial_port;
    logic ref_clk = 1'b0; // Core clock.
    logic rst = 1'b1; // Reset, active high.
    logic scl, sda, sda_out, sda_oe, sclk, ce_n, sdio, so, soe, wr_strobe;
    lhp_pkg::lhp_regs_t regs; // Register contents.
    logic [3:0] wr_index; // Last write index.
    logic [7:0] wr_data, rx; // Last write value, last byte read.
    logic ack; // Acknowledge seen.
    int error_cnt = 0;
    int n_compared = 0;
    int n_wr = 0; // Write strobes counted.

    lhp_serial_port i_lhp_serial_port (.ref_clk(ref_clk), .rst(rst),
        .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_low_bit(1'b0), .addr_strap_high_bit(1'b1),
        .spi_sclk(sclk), .spi_ce_n(ce_n), .spi_sdio_in(sdio),
        .spi_sdio_out(so), .spi_sdio_oe(soe), .reg_file(regs),
        .wr_strobe(wr_strobe), .wr_index(wr_index), .wr_data(wr_data));
    lhp_host_model i_lhp_host_model (.ref_clk(ref_clk), .sda_oe(sda_oe),
        .sdio_out(so), .sdio_oe(soe), .scl(scl), .sda(sda),
        .sclk(sclk), .ce_n(ce_n), .sdio(sdio));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (wr_strobe === 1'b1) begin
            n_wr++;
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wb(input logic [7:0] tx, input logic ak);
        i_lhp_host_model.i2c_byte(tx, 1'b1, rx, ack);
        chk({7'h00, ack}, {7'h00, ak});
    endtask
    task automatic rb(input logic [7:0] exp, input logic am);
        i_lhp_host_model.i2c_byte(8'hFF, am, rx, ack);
        chk(rx, exp);
    endtask
    task automatic sb(input logic [7:0] tx, input logic rd,
                      input logic [7:0] exp);
        i_lhp_host_model.spi_byte(tx, rd, rx);
        if (rd) begin
            chk(rx, exp);
        end
    endtask
    // Foreign address ignored, then a write that runs off the end.
    task automatic sc_i2c_write();
        i_lhp_host_model.i2c_start();
        wb(8'h70, 1'b1);
        i_lhp_host_model.i2c_start();
        wb(8'h74, 1'b0);
        wb(8'h0E, 1'b0);
        wb(8'hA5, 1'b0);
        wb(8'h3C, 1'b0);
        wb(8'h77, 1'b0);
        i_lhp_host_model.i2c_stop();
        chk(regs[14], 8'hA5);
        chk(regs[15], 8'h3C);
        chk(regs[0], lhp_pkg::REG_RESET);
        chk(8'(n_wr), 8'h02);
    endtask
    // Out-of-range pointer: every byte acknowledged, nothing stored.
    task automatic sc_i2c_badptr();
        i_lhp_host_model.i2c_start();
        wb(8'h74, 1'b0);
        wb(8'h00, 1'b0);
        i_lhp_host_model.i2c_start();
        wb(8'h74, 1'b0);
        wb(8'h12, 1'b0);
        wb(8'h55, 1'b0);
        i_lhp_host_model.i2c_stop();
        chk(regs[0], lhp_pkg::REG_RESET);
        chk(8'(n_wr), 8'h02);
    endtask
    // Pointer-only write, repeated start, read across the park value.
    task automatic sc_i2c_read();
        i_lhp_host_model.i2c_start();
        wb(8'h74, 1'b0);
        wb(8'h0E, 1'b0);
        i_lhp_host_model.i2c_start();
        wb(8'h75, 1'b0);
        rb(8'hA5, 1'b0);
        rb(8'h3C, 1'b0);
        rb(lhp_pkg::READ_PAST_END, 1'b1);
        i_lhp_host_model.i2c_stop();
        chk({7'h00, sda_oe}, 8'h00);
    endtask
    task automatic sc_spi_write();
        i_lhp_host_model.spi_open();
        sb(8'h02, 1'b0, 8'h00);
        sb(8'hA5, 1'b0, 8'h00);
        sb(8'h5A, 1'b0, 8'h00);
        i_lhp_host_model.spi_close();
        repeat (6) @(posedge ref_clk);
        chk(regs[2], 8'hA5);
        chk(regs[3], 8'h5A);
        chk({4'h0, wr_index}, 8'h03);
        chk(wr_data, 8'h5A);
    endtask
    // Reads, a read at the park, and a bad address byte.
    task automatic sc_spi_read();
        i_lhp_host_model.spi_open();
        sb(8'h82, 1'b0, 8'h00);
        sb(8'h00, 1'b1, 8'hA5);
        sb(8'h00, 1'b1, 8'h5A);
        chk({7'h00, soe}, 8'h01);
        i_lhp_host_model.spi_close();
        chk({7'h00, soe}, 8'h00);
        i_lhp_host_model.spi_open();
        sb(8'h8F, 1'b0, 8'h00);
        sb(8'h00, 1'b1, 8'h3C);
        sb(8'h00, 1'b1, lhp_pkg::READ_PAST_END);
        i_lhp_host_model.spi_close();
        i_lhp_host_model.spi_open();
        sb(8'hA2, 1'b0, 8'h00);
        // Undriven, the model's pin flips from its last level each bit.
        sb(8'h00, 1'b1, 8'hAA);
        chk({7'h00, soe}, 8'h00);
        i_lhp_host_model.spi_close();
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sc_i2c_write();
        sc_i2c_badptr();
        sc_i2c_read();
        sc_spi_write();
        sc_spi_read();
        complete_run();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        error_cnt++;
        complete_run();
    end
endmodule

`default_nettype wire
